// ===== dv/testbench.sv
// self-checking bench for the clock gear block
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module testbench;
    import scg_pkg::*;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic core_clk;
    logic rst_n;
    logic porRst_n;
    logic [7:0] addr;
    logic [31:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic lowSpeedClk = 1'h0; // slow clock, ten cycles a period
    int lsCnt = 0;
    logic [31:0] readData;
    logic gearTick;
    logic periphTick;
    logic prescaleTick;
    logic clockOutPin;
    logic pllEnable;
    wire logic [3:0] ticks; // tick outputs by index
    int n_mismatch;
    int checks_done;
    logic [31:0] mdl [0:7]; // model of the register words
    int gExp; // model gear period in cycles
    int pExp; // model prescale ratio
    int prevP [4]; // last settled period of each tick
    assign ticks = {clockOutPin, prescaleTick, periphTick, gearTick};
    scg_clock_gear uut
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .porRst_n(porRst_n),
        .addr(addr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .lowSpeedClk(lowSpeedClk),
        .readData(readData),
        .gearTick(gearTick),
        .periphTick(periphTick),
        .prescaleTick(prescaleTick),
        .clockOutPin(clockOutPin),
        .pllEnable(pllEnable)
    );
    // clock at 100 MHz
    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // low speed level toggles every five cycles
    always @(posedge core_clk)
    begin
        if (lsCnt == 4)
        begin
            lsCnt <= 0;
            lowSpeedClk <= ~lowSpeedClk;
        end
        else
            lsCnt <= lsCnt + 1;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one-cycle write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'h1;
        @(posedge core_clk);
        wrStrobe <= 1'h0;
    endtask : wr
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rdStrobe <= 1'h1;
        @(posedge core_clk);
        rdStrobe <= 1'h0;
        @(posedge core_clk);
        d = readData;
    endtask : rd
    // read and compare with the model, unmapped reads give zero
    task automatic rdc(input logic [7:0] a);
        logic [31:0] d;
        rd(a, d);
        chk("readData", d, (a <= 8'h14) ? mdl[a[4:2]] : 32'h0);
    endtask : rdc
    // cycles between two ticks of one output, bounded
    task automatic per(input int i, output int p);
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (ticks[i] !== 1'h1 && k < 600);
        p = 0;
        do
        begin
            @(posedge core_clk);
            p++;
        end
        while (ticks[i] !== 1'h1 && p < 600);
    endtask : per
    // write control fields with unused bits set, then measure all ticks
    task automatic cfg(input int co, input int ps, input int pr, input int g);
        int p;
        int lo;
        int hi;
        int ep [4];
        mdl[0] = {14'h0, co[1:0], 3'h0, ps[0], 1'h0, pr[2:0], 5'h0, g[2:0]};
        wr(`SCG_OFS_SYSCTL, {14'h3FFF, co[1:0], 3'h7, ps[0], 1'h1, pr[2:0],
                             5'h1F, g[2:0]});
        // reserved codes leave the ratio in force
        if (g == 0 || (g >= 4 && g <= 6))
            gExp = (g == 0) ? 1 : 1 << (g - 3);
        if (pr <= 5)
            pExp = 1 << pr;
        ep[0] = gExp;
        ep[1] = ps ? 1 : gExp;
        ep[2] = ep[1] * pExp;
        ep[3] = (co == 0) ? 10 : (co == 1) ? 2 : (co == 2) ? 1 : ep[2];
        for (int i = 0; i < 4; i++)
        begin
            lo = (prevP[i] < ep[i]) ? prevP[i] : ep[i];
            hi = (prevP[i] > ep[i]) ? prevP[i] : ep[i];
            per(i, p);
            if (i < 3)
                chk("pulseLen", 32'(p >= lo && p <= hi), 32'h1);
            per(i, p);
            chk("tickPeriod", p, ep[i]);
            prevP[i] = ep[i];
        end
        rdc(`SCG_OFS_SYSCTL);
    endtask : cfg
    // verdict and end of run
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // reset model state as a warm reset leaves it
    task automatic warm_model;
        for (int i = 0; i < 5; i++)
            mdl[i] = 32'h0;
        mdl[0] = 32'h0001_0000;
        gExp = 1;
        pExp = 1;
        prevP = '{1, 1, 1, 2};
    endtask : warm_model
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        int seed;
        rst_n = 1'h0;
        porRst_n = 1'h0;
        addr = 8'h0;
        wrData = 32'h0;
        wrStrobe = 1'h0;
        rdStrobe = 1'h0;
        n_mismatch = 0;
        checks_done = 0;
        seed = $urandom(1);
        foreach (mdl[i])
            mdl[i] = 32'h0;
        warm_model();
        mdl[5] = 32'h1;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        porRst_n <= 1'h1;
        @(posedge core_clk);
        chk("pllEnable", pllEnable, 32'h0);
        for (int a = 0; a <= 20; a += 4)
            rdc(8'(a));
        wr(8'h20, $urandom);
        rdc(8'h20);
        rdc(`SCG_OFS_SYSCTL);
        foreach (mdl[i])
            if (i == 1 || i == 2 || i == 4)
            begin
                mdl[i] = $urandom;
                wr(8'(i * 4), mdl[i]);
                rdc(8'(i * 4));
            end
        wr(`SCG_OFS_PLLSEL, 32'h1);
        mdl[3] = 32'h1;
        repeat (2) @(posedge core_clk);
        chk("pllEnable", pllEnable, 32'h1);
        foreach (prevP[i])
            if (i < 6)
                cfg(2, 0, 0, (i == 0) ? 0 : i + 3);
        cfg(2, 0, 0, 1);
        cfg(2, 0, 0, 7);
        for (int pr = 0; pr < 8; pr++)
            cfg(3, 1, pr, 6);
        cfg(0, 0, 2, 4);
        cfg(1, 1, 0, 0);
        wr(`SCG_OFS_CAUSE, 32'h1);
        mdl[5] = 32'h0;
        rdc(`SCG_OFS_CAUSE);
        rst_n <= 1'h0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'h1;
        warm_model();
        mdl[5] = 32'h2;
        @(posedge core_clk);
        chk("pllEnable", pllEnable, 32'h0);
        for (int a = 0; a <= 20; a += 4)
            rdc(8'(a));
        cfg(2, 0, 0, 0);
        porRst_n <= 1'h0;
        repeat (6) @(posedge core_clk);
        porRst_n <= 1'h1;
        mdl[5] = 32'h1;
        rdc(`SCG_OFS_CAUSE);
        // short pin pulse: no warm flag, cold flag kept
        rst_n <= 1'h0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        rdc(`SCG_OFS_CAUSE);
        tally_and_finish();
    end
    // cut a hang short
    initial
    begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire

// ===== verilog/scg_clock_gear.sv
// clock gear, peripheral prescaler, clock output select and reset cause
// Notes on behaviour
// - cause flags survive warm reset, cold sets the cold flag and clears the warm one
// - pll off after reset until software sets
// - six registers at offsets zero through 0x14
// - bits 17-16 pick clock output, reset 01
// - bit 12 picks peripheral source, reset 0
// - bits 10-8 prescale by one to 32
// - bits 2-0 gear divide one, two, four, eight
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module scg_clock_gear
    import scg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic porRst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic lowSpeedClk,
    output logic [31:0] readData,
    output logic gearTick,
    output logic periphTick,
    output logic prescaleTick,
    output logic clockOutPin,
    output logic pllEnable
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // gear code to {valid, log2 ratio}
    function automatic logic [3:0] gearDecode(input logic [2:0] c);
        case (c)
            3'h0: gearDecode = 4'h8;
            3'h4: gearDecode = 4'h9;
            3'h5: gearDecode = 4'hA;
            3'h6: gearDecode = 4'hB;
            default: gearDecode = 4'h0;
        endcase
    endfunction : gearDecode

    // address match for a strobe
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    wire anyRst_n = rst_n & porRst_n; // warm or cold reset
    scg_sysctl_t sysctl_ff; // system control fields
    logic [31:0] osc_ff; // oscillator control word
    logic [31:0] stby_ff; // standby control word
    logic [31:0] cksel_ff; // system clock select word
    logic pll_ff; // pll enable bit
    logic [1:0] cause_ff; // {warm, cold} reset cause
    logic [3:0] lowCnt_ff; // cycles the reset pin has been low
    logic [31:0] readData_ff; // read answer
    logic [1:0] coAct_ff; // clock output source in force
    logic psrcAct_ff; // peripheral source in force
    logic lowPrev_ff; // low speed clock last cycle
    logic halfTog_ff; // half rate phase
    logic clockOut_ff; // clock output tick
    logic periph_ff; // peripheral source tick
    logic pll_out_ff; // pll enable output

    wire wrSys = wrStrobe && hit(addr, `SCG_OFS_SYSCTL);
    wire wrOsc = wrStrobe && hit(addr, `SCG_OFS_OSC);
    wire wrStby = wrStrobe && hit(addr, `SCG_OFS_STBY);
    wire wrPll = wrStrobe && hit(addr, `SCG_OFS_PLLSEL);
    wire wrCk = wrStrobe && hit(addr, `SCG_OFS_CKSEL);
    wire wrCause = wrStrobe && hit(addr, `SCG_OFS_CAUSE);

    // system control readback; unused bits are constant zero
    wire [31:0] sysWord = (32'(sysctl_ff.coSel) << `SCG_POS_COSEL)
        | (32'(sysctl_ff.psrcSel) << `SCG_POS_PSRC)
        | (32'(sysctl_ff.presc) << `SCG_POS_PRESC)
        | (32'(sysctl_ff.gear) << `SCG_POS_GEAR);
    // written fields; only the defined bits are taken
    wire scg_sysctl_t sysNew = '{coSel: scg_co_sel_t'(wrData[17:16]),
        psrcSel: wrData[12], presc: wrData[10:8], gear: wrData[2:0]};

    // read mux; unmapped offsets answer zero
    wire [31:0] rdMux =
        hit(addr, `SCG_OFS_SYSCTL) ? sysWord :
        hit(addr, `SCG_OFS_OSC) ? osc_ff :
        hit(addr, `SCG_OFS_STBY) ? stby_ff :
        hit(addr, `SCG_OFS_PLLSEL) ? {31'h0, pll_ff} :
        hit(addr, `SCG_OFS_CKSEL) ? cksel_ff :
        hit(addr, `SCG_OFS_CAUSE) ? {30'h0, cause_ff} : 32'h0;

    // software registers, loaded with their reset values by warm or cold reset
    always_ff @(posedge core_clk)
    begin
        if (!anyRst_n)
        begin
            sysctl_ff <= '{coSel: scg_co_sel_t'(`SCG_RST_COSEL),
                psrcSel: `SCG_RST_PSRC, presc: `SCG_RST_PRESC,
                gear: `SCG_RST_GEAR};
            osc_ff <= `SCG_RST_OSC;
            stby_ff <= `SCG_RST_STBY;
            cksel_ff <= `SCG_RST_CKSEL;
            pll_ff <= `SCG_RST_PLL;
        end
        else
        begin
            if (wrSys)
                sysctl_ff <= sysNew;
            if (wrOsc)
                osc_ff <= wrData;
            if (wrStby)
                stby_ff <= wrData;
            if (wrCk)
                cksel_ff <= wrData;
            if (wrPll)
                pll_ff <= wrData[0];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!anyRst_n)
            readData_ff <= 32'h0;
        else
            readData_ff <= rdStrobe ? rdMux : 32'h0;
    end

    // ------------------------------------------------------------------
    // reset cause, kept through warm reset
    // ------------------------------------------------------------------
    wire warmSeen = !rst_n && (lowCnt_ff == `SCG_WARM_MIN_CYCLES - 4'h1);

    // pin low counter; a pulse shorter than the minimum sets no warm flag
    always_ff @(posedge core_clk)
    begin
        if (!porRst_n)
            lowCnt_ff <= 4'h0;
        else if (rst_n)
            lowCnt_ff <= 4'h0;
        else if (lowCnt_ff != `SCG_WARM_MIN_CYCLES)
            lowCnt_ff <= lowCnt_ff + 4'h1;
    end

    // flags: only cold reset reloads them, cold set; hardware set beats software clear
    always_ff @(posedge core_clk)
    begin
        if (!porRst_n)
            cause_ff <= `SCG_RST_CAUSE;
        else
        begin
            cause_ff[0] <= cause_ff[0] & ~(wrCause & rst_n & wrData[0]);
            cause_ff[1] <= warmSeen
                | (cause_ff[1] & ~(wrCause & rst_n & wrData[1]));
        end
    end

    // ------------------------------------------------------------------
    // gear and prescaler dividers
    // ------------------------------------------------------------------
    wire [3:0] gearDec = gearDecode(sysctl_ff.gear);
    wire gearTickW; // gear divided high speed tick
    wire prescTickW; // prescaler tick
    wire psrcTick = psrcAct_ff ? 1'b1 : gearTickW;

    // high speed clock divided by the gear; reserved codes keep the ratio
    scg_pow2_div #(.CW(3)) u_gear (
        .core_clk(core_clk),
        .rst_n(anyRst_n),
        .tickIn(1'b1),
        .ratioReq(gearDec[2:0]),
        .ratioOk(gearDec[3]),
        .tickOut(gearTickW),
        .ratioAct()
    );

    // peripheral source divided by one to 32; reserved codes ignored
    scg_pow2_div #(.CW(5)) u_presc (
        .core_clk(core_clk),
        .rst_n(anyRst_n),
        .tickIn(psrcTick),
        .ratioReq(sysctl_ff.presc),
        .ratioOk(sysctl_ff.presc <= 3'h5),
        .tickOut(prescTickW),
        .ratioAct()
    );

    // ------------------------------------------------------------------
    // clock output selection
    // ------------------------------------------------------------------
    wire lowTick = lowSpeedClk & ~lowPrev_ff; // low speed rising edge
    wire srcTick = (coAct_ff == SCG_CO_LOW) ? lowTick :
        (coAct_ff == SCG_CO_HALF) ? halfTog_ff :
        (coAct_ff == SCG_CO_SYS) ? 1'b1 : prescTickW;

    // sources switch only on a tick of the current one, no runt pulse
    always_ff @(posedge core_clk)
    begin
        if (!anyRst_n)
        begin
            coAct_ff <= `SCG_RST_COSEL;
            psrcAct_ff <= `SCG_RST_PSRC;
            lowPrev_ff <= lowSpeedClk; // no false edge if the pin is high
            halfTog_ff <= 1'b0;
            clockOut_ff <= 1'b0;
            periph_ff <= 1'b0;
            pll_out_ff <= 1'b0;
        end
        else
        begin
            lowPrev_ff <= lowSpeedClk;
            halfTog_ff <= ~halfTog_ff;
            clockOut_ff <= srcTick;
            periph_ff <= psrcTick;
            pll_out_ff <= pll_ff;
            if (srcTick)
                coAct_ff <= sysctl_ff.coSel;
            if (gearTickW)
                psrcAct_ff <= sysctl_ff.psrcSel;
        end
    end

    assign readData = readData_ff;
    assign gearTick = gearTickW;
    assign periphTick = periph_ff;
    assign prescaleTick = prescTickW;
    assign clockOutPin = clockOut_ff;
    assign pllEnable = pll_out_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_warm_min_hold: assert property (@(posedge core_clk)
        disable iff (!porRst_n) $rose(cause_ff[1]) |-> $past(!rst_n, 12))
        else $error("warm flag set by a short reset pulse");
    a_cause_kept_warm: assert property (@(posedge core_clk)
        disable iff (!porRst_n) (!rst_n && cause_ff[0]) |=> cause_ff[0])
        else $error("warm reset cleared cold flag");
    a_pll_off_reset: assert property (@(posedge core_clk)
        disable iff (!porRst_n) (!rst_n ##1 rst_n [*2]) |-> !pllEnable
        or $past(wrPll, 1))
        else $error("pll active after reset");
    a_pll_needs_write: assert property (@(posedge core_clk)
        disable iff (!anyRst_n) $rose(pllEnable) |->
        $past(wrPll && wrData[0], 2))
        else $error("pll enabled without a write");
    a_pll_read_decode: assert property (@(posedge core_clk)
        disable iff (!anyRst_n) (rdStrobe && addr == `SCG_OFS_PLLSEL)
        |=> readData == {31'h0, $past(pll_ff)})
        else $error("pll select read wrong");
    a_cosel_reset: assert property (@(posedge core_clk)
        (!anyRst_n ##1 anyRst_n) |-> sysctl_ff.coSel == SCG_CO_HALF)
        else $error("clock output select reset wrong");
    a_half_rate_out: assert property (@(posedge core_clk)
        disable iff (!anyRst_n) (anyRst_n && coAct_ff == SCG_CO_HALF) [*3]
        |-> clockOutPin != $past(clockOutPin))
        else $error("half rate output not alternating");
    a_psrc_reset: assert property (@(posedge core_clk)
        (!anyRst_n ##1 anyRst_n) |-> !sysctl_ff.psrcSel && !psrcAct_ff)
        else $error("peripheral source reset wrong");
    a_presc_reset: assert property (@(posedge core_clk)
        (!anyRst_n ##1 anyRst_n) |-> sysctl_ff.presc == 3'h0)
        else $error("prescaler reset wrong");
    a_gear_full_rate: assert property (@(posedge core_clk)
        (!anyRst_n ##1 anyRst_n [*2]) |-> gearTick)
        else $error("undivided gear not ticking every cycle");
    a_unused_zero: assert property (@(posedge core_clk)
        disable iff (!anyRst_n) (rdStrobe && addr == `SCG_OFS_SYSCTL)
        |=> (readData & 32'hFFFC_E8F8) == 32'h0)
        else $error("unused control bits not zero");
    a_clkout_switch: assert property (@(posedge core_clk)
        disable iff (!anyRst_n) coAct_ff != $past(coAct_ff) |->
        $past(srcTick))
        else $error("clock output switched mid period");

    c_warm_reset: cover property (@(posedge core_clk) $rose(cause_ff[1]));
    c_co_timer: cover property (@(posedge core_clk)
        coAct_ff == SCG_CO_TMR && clockOutPin);
    c_presc_32: cover property (@(posedge core_clk)
        sysctl_ff.presc == 3'h5 && prescaleTick);
    c_psrc_fast: cover property (@(posedge core_clk) psrcAct_ff && gearTick);
endmodule : scg_clock_gear
`default_nettype wire

// ===== verilog/scg_params.svh
// offsets, field positions, reset values and counts of the clock gear block
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH
// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define SCG_OFS_SYSCTL 8'h00
`define SCG_OFS_OSC 8'h04
`define SCG_OFS_STBY 8'h08
`define SCG_OFS_PLLSEL 8'h0C
`define SCG_OFS_CKSEL 8'h10
`define SCG_OFS_CAUSE 8'h14
// ------------------------------------------------------------------
// system control field positions
// ------------------------------------------------------------------
`define SCG_POS_COSEL 16
`define SCG_POS_PSRC 12
`define SCG_POS_PRESC 8
`define SCG_POS_GEAR 0
// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SCG_RST_COSEL 2'h1
`define SCG_RST_PSRC 1'h0
`define SCG_RST_PRESC 3'h0
`define SCG_RST_GEAR 3'h0
`define SCG_RST_OSC 32'h0
`define SCG_RST_STBY 32'h0
`define SCG_RST_CKSEL 32'h0
`define SCG_RST_PLL 1'h0
`define SCG_RST_CAUSE 2'h1
// ------------------------------------------------------------------
// counts
// ------------------------------------------------------------------
`define SCG_WARM_MIN_CYCLES 4'hC
`endif

// ===== verilog/scg_pkg.sv
// types shared by the clock gear block
`default_nettype none
package scg_pkg;
    // clock output source codes
    typedef enum logic [1:0]
    {
        SCG_CO_LOW = 2'b00,
        SCG_CO_HALF = 2'b01,
        SCG_CO_SYS = 2'b10,
        SCG_CO_TMR = 2'b11
    } scg_co_sel_t;

    // stored fields of the system control register
    typedef struct packed
    {
        scg_co_sel_t coSel;
        logic psrcSel;
        logic [2:0] presc;
        logic [2:0] gear;
    } scg_sysctl_t;
endpackage : scg_pkg
`default_nettype wire

// ===== verilog/scg_pow2_div.sv
// power of two tick divider that takes a new ratio only at a period end
`timescale 1ns/1ps
`default_nettype none
module scg_pow2_div #(
    parameter int CW = 5
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tickIn,
    input wire logic [2:0] ratioReq,
    input wire logic ratioOk,
    output logic tickOut,
    output logic [2:0] ratioAct
);
    logic [CW-1:0] cnt_ff; // enabled ticks seen in this period
    logic [2:0] ratio_ff; // log2 of the divide ratio in force
    logic tick_ff; // one pulse per completed period
    wire [CW-1:0] lastCnt = CW'((32'h1 << ratio_ff) - 32'h1);
    wire wrap = tickIn && (cnt_ff == lastCnt);

    // counter; the ratio only moves at wrap so no period is cut short
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            ratio_ff <= 3'h0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= wrap;
            if (wrap)
            begin
                cnt_ff <= '0;
                ratio_ff <= ratioOk ? ratioReq : ratio_ff;
            end
            else if (tickIn)
                cnt_ff <= cnt_ff + CW'(1);
        end
    end

    assign tickOut = tick_ff;
    assign ratioAct = ratio_ff;

    // ratio never changes mid period
    a_ratio_at_wrap: assert property (@(posedge core_clk)
        disable iff (!rst_n) ratio_ff != $past(ratio_ff) |-> $past(wrap))
        else $error("divider ratio changed inside a period");
endmodule : scg_pow2_div
`default_nettype wire
